/* rtl/adc_seq_pkg.sv */
// Shared constants and types for the converter sequencer
package adc_seq_pkg;

  // Master clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int DIV_RATIO = 4;

  // Variant codes on variant_sel
  localparam logic [1:0] VAR_FAST12 = 2'h0;
  localparam logic [1:0] VAR_STD12 = 2'h1;
  localparam logic [1:0] VAR_14 = 2'h2;
  localparam logic [1:0] VAR_16 = 2'h3;

  // Conversion timing in master clock cycles
  localparam int CONV12_CYC = 49;
  localparam int CONV14_CYC = 57;
  localparam int CONV16_CYC = 65;
  localparam int INTERLEAVE_EXTRA = 20;
  localparam int TRACK_DONE_DELAY = 15;
  localparam int EOC_READ_CYC = 4;

  // Acquisition time
  localparam int ACQ_EXTRA_CLK = 6;
  localparam int ACQ_FAST_NS = 1320;
  localparam int ACQ_STD_NS = 2250;
  localparam int ACQ_FAST_CYC =
    ACQ_EXTRA_CLK + (ACQ_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_STD_CYC =
    ACQ_EXTRA_CLK + (ACQ_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Calibration lengths
  localparam int CAL_FAST12_CYC = 58280;
  localparam int CAL_STD_CYC = 1441020;
  localparam int TRIM_FAST12_CONV = 2014;
  localparam int TRIM_STD_CONV = 72051;

  // Counter widths
  localparam int CNT_W = 21;
  localparam int TRIM_W = 17;
  localparam int ACQ_W = 7;

  // Values after reset
  localparam logic EOC_N_RESET = 1'h1;
  localparam logic TRACK_DONE_N_RESET = 1'h1;
  localparam logic CAL_RESET = 1'h1;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_CAL = 4'h1,
    ST_TRACK = 4'h2,
    ST_SYNC = 4'h4,
    ST_CONVERT = 4'h8
  } seq_state_e;

endpackage

/* rtl/conv_tick_if.sv */
// Internal conversion clock tick carrier
`timescale 1ns/10ps
interface conv_tick_if;
  logic clr;
  logic tick;
  modport gen(input clr, output tick);
  modport user(output clr, input tick);
endinterface

/* rtl/conv_clock_gen.sv */
// Divide-by-four internal conversion clock tick
`timescale 1ns/10ps
module conv_clock_gen (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Tick output
  conv_tick_if.gen bus
);

  logic [1:0] phase;

  // Phase counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'h0;
    end else if (bus.clr) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Delayed tick, one per four cycles
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus.tick <= 1'h0;
    end else if (bus.clr) begin
      bus.tick <= 1'h0;
    end else begin
      bus.tick <= (phase == 2'(adc_seq_pkg::DIV_RATIO - 1));
    end
  end

  a_tick_period: assert property (
    @(posedge mclk) disable iff (!arst_n || bus.clr)
    bus.tick |=> !bus.tick [*3] ##1 bus.tick
  ) else $error("internal tick not every four cycles");

endmodule

/* rtl/sar_adc_sample_cal_sequencer.sv */
// Conversion, acquisition and calibration sequencer
// Summary of operation
// - Acquisition needs six cycles plus fixed time
// - Internal clock is master clock divided four
// - Unsynchronised strobe: hold now, start on tick
// - Conversion is 49, 57 or 65 cycles
// - Async worst case adds three cycles
// - Track done falls 15 cycles after done
// - Loopback gives 64, 72 or 80 cycles
// - Reset overrides all, restarts full calibration
// - Reset pin high clears, release calibrates
// - Calibration lasts 58280 or 1441020 cycles
// - Select, register select, strobe low resets
// - Done stays high during calibration
// - Strobe ignored while calibrating
// - Standalone 14/16 bit keeps done high after calibration
// - Interleave trims once per full set
// - Interleave adds 20 cycles per conversion
// - Falling strobe starts; long low restarts
// - Trim control latched while chip selected
// - Done falls at end, rises after read
`timescale 1ns/10ps
module sar_adc_sample_cal_sequencer #(
  parameter int CAL_FAST12_CYC = adc_seq_pkg::CAL_FAST12_CYC,
  parameter int CAL_STD_CYC = adc_seq_pkg::CAL_STD_CYC,
  parameter int TRIM_FAST12_CONV = adc_seq_pkg::TRIM_FAST12_CONV,
  parameter int TRIM_STD_CONV = adc_seq_pkg::TRIM_STD_CONV
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Host control pins
  input wire logic hw_reset,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic register_select,
  input wire logic sample_strobe_n,
  input wire logic background_trim_n,
  // Static configuration
  input wire logic [1:0] variant_sel,
  input wire logic fast_grade,
  // Status outputs
  output logic conversion_done_n,
  output logic track_done_n,
  output logic tracking,
  output logic converting,
  output logic calibrating,
  output logic acquisition_ok,
  output logic interleave_active,
  output logic trim_update
);

  localparam int CNT_W = adc_seq_pkg::CNT_W;
  localparam int TRIM_W = adc_seq_pkg::TRIM_W;
  localparam int ACQ_W = adc_seq_pkg::ACQ_W;

  adc_seq_pkg::seq_state_e state;
  adc_seq_pkg::seq_state_e next_state;
  logic soft_reset;
  logic any_reset;
  logic data_read;
  logic tick;
  logic cal_end;
  logic conv_end;
  logic conv_start;
  logic leave_track;
  logic [CNT_W-1:0] cnt;
  logic [3:0] trk_cnt;
  logic [ACQ_W-1:0] acq_cnt;
  logic [2:0] rd_cnt;
  logic [TRIM_W-1:0] trim_cnt;

  conv_tick_if tick_bus();

  conv_clock_gen u_clock_gen (
    .mclk(mclk),
    .arst_n(arst_n),
    .bus(tick_bus.gen)
  );

  // Fast 12-bit variant test
  function automatic logic is_fast12(input logic [1:0] v);
    is_fast12 = (v == adc_seq_pkg::VAR_FAST12);
  endfunction

  // Conversion length including interleave step
  function automatic logic [CNT_W-1:0] conv_len(input logic [1:0] v,
                                                input logic trim);
    logic [CNT_W-1:0] base;
    base = CNT_W'(adc_seq_pkg::CONV16_CYC);
    case (v)
      adc_seq_pkg::VAR_FAST12, adc_seq_pkg::VAR_STD12: begin
        base = CNT_W'(adc_seq_pkg::CONV12_CYC);
      end
      adc_seq_pkg::VAR_14: begin
        base = CNT_W'(adc_seq_pkg::CONV14_CYC);
      end
      default: begin
        base = CNT_W'(adc_seq_pkg::CONV16_CYC);
      end
    endcase
    conv_len = trim ? base + CNT_W'(adc_seq_pkg::INTERLEAVE_EXTRA) : base;
  endfunction

  // Full calibration length
  function automatic logic [CNT_W-1:0] cal_len(input logic [1:0] v);
    cal_len = is_fast12(v) ? CNT_W'(CAL_FAST12_CYC) : CNT_W'(CAL_STD_CYC);
  endfunction

  // Acquisition length
  function automatic logic [ACQ_W-1:0] acq_len(input logic [1:0] v,
                                               input logic fast);
    acq_len = (is_fast12(v) && fast) ? ACQ_W'(adc_seq_pkg::ACQ_FAST_CYC)
                                     : ACQ_W'(adc_seq_pkg::ACQ_STD_CYC);
  endfunction

  // Conversions per interleave set
  function automatic logic [TRIM_W-1:0] trim_len(input logic [1:0] v);
    trim_len = is_fast12(v) ? TRIM_W'(TRIM_FAST12_CONV)
                            : TRIM_W'(TRIM_STD_CONV);
  endfunction

  // Pin decode
  assign soft_reset = !chip_select_n && !register_select &&
                      !sample_strobe_n;
  assign any_reset = hw_reset || soft_reset;
  // Data read; also the standalone wiring
  assign data_read = !chip_select_n && !read_n && register_select;
  assign tick_bus.clr = any_reset;
  assign tick = tick_bus.tick;

  assign cal_end = (state == adc_seq_pkg::ST_CAL) &&
                   (cnt == cal_len(variant_sel) - CNT_W'(1));
  assign conv_end = (state == adc_seq_pkg::ST_CONVERT) &&
                    (cnt == conv_len(variant_sel, interleave_active) -
                     CNT_W'(2));
  assign conv_start = (next_state == adc_seq_pkg::ST_CONVERT) &&
                      (state != adc_seq_pkg::ST_CONVERT);
  assign leave_track = (state == adc_seq_pkg::ST_TRACK) &&
                       (next_state != adc_seq_pkg::ST_TRACK);

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      adc_seq_pkg::ST_CAL: begin
        if (cal_end) begin
          next_state = adc_seq_pkg::ST_TRACK;
        end
      end
      adc_seq_pkg::ST_TRACK: begin
        if (!sample_strobe_n) begin
          next_state = tick ? adc_seq_pkg::ST_CONVERT
                            : adc_seq_pkg::ST_SYNC;
        end
      end
      adc_seq_pkg::ST_SYNC: begin
        if (tick) begin
          next_state = adc_seq_pkg::ST_CONVERT;
        end
      end
      adc_seq_pkg::ST_CONVERT: begin
        if (conv_end) begin
          next_state = adc_seq_pkg::ST_TRACK;
        end
      end
      default: begin
        next_state = adc_seq_pkg::ST_CAL;
      end
    endcase
    if (any_reset) begin
      next_state = adc_seq_pkg::ST_CAL;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= adc_seq_pkg::ST_CAL;
    end else begin
      state <= next_state;
    end
  end

  // Calibration and conversion cycle counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
    end else if (any_reset || next_state != state) begin
      cnt <= '0;
    end else if (state == adc_seq_pkg::ST_CAL ||
                 state == adc_seq_pkg::ST_CONVERT) begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  // Status flags follow the next state
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tracking <= 1'h0;
      converting <= 1'h0;
      calibrating <= adc_seq_pkg::CAL_RESET;
    end else begin
      tracking <= (next_state == adc_seq_pkg::ST_TRACK);
      converting <= (next_state == adc_seq_pkg::ST_SYNC) ||
                    (next_state == adc_seq_pkg::ST_CONVERT);
      calibrating <= (next_state == adc_seq_pkg::ST_CAL);
    end
  end

  // Conversion done
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      conversion_done_n <= adc_seq_pkg::EOC_N_RESET;
    end else if (any_reset) begin
      conversion_done_n <= 1'h1;
    end else if (conv_end) begin
      conversion_done_n <= 1'h0;
    end else if (cal_end) begin
      conversion_done_n <= data_read && !is_fast12(variant_sel) &&
                           variant_sel != adc_seq_pkg::VAR_STD12;
    end else if (conv_start) begin
      conversion_done_n <= 1'h1;
    end else if (rd_cnt == 3'(adc_seq_pkg::EOC_READ_CYC - 1)) begin
      conversion_done_n <= 1'h1;
    end
  end

  // Cycles since first read after done fell
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_cnt <= 3'h0;
    end else if (any_reset || conversion_done_n || conv_end) begin
      rd_cnt <= 3'h0;
    end else if (rd_cnt != 3'h0 || data_read) begin
      rd_cnt <= rd_cnt + 3'h1;
    end
  end

  // Tracking time counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trk_cnt <= 4'h0;
    end else if (state != adc_seq_pkg::ST_TRACK) begin
      trk_cnt <= 4'h0;
    end else if (trk_cnt != 4'(adc_seq_pkg::TRACK_DONE_DELAY)) begin
      trk_cnt <= trk_cnt + 4'h1;
    end
  end

  // Track done
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      track_done_n <= adc_seq_pkg::TRACK_DONE_N_RESET;
    end else if (any_reset || leave_track) begin
      track_done_n <= 1'h1;
    end else if (state == adc_seq_pkg::ST_TRACK &&
                 trk_cnt == 4'(adc_seq_pkg::TRACK_DONE_DELAY - 1)) begin
      track_done_n <= 1'h0;
    end
  end

  // Acquisition timer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acq_cnt <= '0;
    end else if (state != adc_seq_pkg::ST_TRACK) begin
      acq_cnt <= '0;
    end else if (!acquisition_ok) begin
      acq_cnt <= acq_cnt + ACQ_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acquisition_ok <= 1'h0;
    end else begin
      acquisition_ok <= (next_state == adc_seq_pkg::ST_TRACK) &&
                        (acquisition_ok ||
                         (state == adc_seq_pkg::ST_TRACK &&
                          acq_cnt == acq_len(variant_sel, fast_grade) -
                          ACQ_W'(1)));
    end
  end

  // Interleave enable, transparent while selected
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      interleave_active <= 1'h0;
    end else if (hw_reset) begin
      interleave_active <= 1'h0;
    end else if (!chip_select_n) begin
      interleave_active <= !background_trim_n;
    end
  end

  // Interleave set counter and trim update pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trim_cnt <= '0;
      trim_update <= 1'h0;
    end else if (any_reset) begin
      trim_cnt <= '0;
      trim_update <= 1'h0;
    end else if (conv_end && interleave_active) begin
      if (trim_cnt == trim_len(variant_sel) - TRIM_W'(1)) begin
        trim_cnt <= '0;
        trim_update <= 1'h1;
      end else begin
        trim_cnt <= trim_cnt + TRIM_W'(1);
        trim_update <= 1'h0;
      end
    end else begin
      trim_update <= 1'h0;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_track_after_done: assert property (
    $fell(conversion_done_n) && sample_strobe_n && tracking
    |-> ##15 ($fell(track_done_n) || !tracking)
  ) else $error("track done not 15 cycles after done");

  a_conv_len_plain: assert property (
    disable iff (!arst_n || any_reset)
    (state == adc_seq_pkg::ST_TRACK || state == adc_seq_pkg::ST_SYNC) &&
    next_state == adc_seq_pkg::ST_CONVERT &&
    variant_sel == adc_seq_pkg::VAR_FAST12 && !interleave_active
    |-> ##49 $fell(conversion_done_n)
  ) else $error("12-bit conversion length wrong");

  a_conv_len_trim: assert property (
    disable iff (!arst_n || any_reset)
    (state == adc_seq_pkg::ST_TRACK || state == adc_seq_pkg::ST_SYNC) &&
    next_state == adc_seq_pkg::ST_CONVERT &&
    variant_sel == adc_seq_pkg::VAR_FAST12 && interleave_active
    |-> ##69 $fell(conversion_done_n)
  ) else $error("interleave conversion length wrong");

  a_sync_wait: assert property (
    disable iff (!arst_n || any_reset)
    $rose(converting) |-> ##[0:3] (state == adc_seq_pkg::ST_CONVERT)
  ) else $error("conversion start not within four cycles");

  a_cal_done_high: assert property (
    calibrating |-> conversion_done_n
  ) else $error("done low during calibration");

  a_cal_ignores_strobe: assert property (
    state == adc_seq_pkg::ST_CAL |=> !converting
  ) else $error("conversion started during calibration");

  a_reset_clears: assert property (
    any_reset |=> calibrating && conversion_done_n && track_done_n
  ) else $error("reset did not restart calibration");

  a_soft_reset: assert property (
    !chip_select_n && !register_select && !sample_strobe_n
    |=> calibrating && !converting
  ) else $error("software reset not taken");

  a_start_raises: assert property (
    $rose(state == adc_seq_pkg::ST_CONVERT) |-> track_done_n &&
    conversion_done_n
  ) else $error("track done or done low at conversion start");

  a_read_release: assert property (
    disable iff (!arst_n || any_reset)
    !conversion_done_n && data_read && tracking
    |-> ##[1:4] conversion_done_n
  ) else $error("done not released within four cycles of read");

endmodule

/* testbench/host_strobe_model.sv */
// Host side strobe source for the converter sequencer
`timescale 1ns/10ps
module host_strobe_model (
  // Clock
  input wire logic mclk,
  // Bench commands
  input wire logic loopback,
  input wire logic strobe_req,
  input wire logic force_req,
  // Device feedback
  input wire logic acquisition_ok,
  input wire logic track_done_n,
  // Strobe to the device
  output logic sample_strobe_n
);
  logic held_n = 1'h1;
  int low_left = 0;

  // Loopback ties the strobe to track done
  assign sample_strobe_n = loopback ? track_done_n : held_n;

  // Low pulse of three cycles, far below a conversion
  always @(posedge mclk) begin
    if (low_left > 1) begin
      low_left <= low_left - 1;
    end else if (low_left == 1) begin
      low_left <= 0;
      held_n <= 1'h1;
    end else if (strobe_req && (acquisition_ok || force_req)) begin
      held_n <= 1'h0;
      low_left <= 3;
    end
  end
endmodule

/* testbench/tb_sar_adc_sample_cal_sequencer.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
module tb_sar_adc_sample_cal_sequencer;
  logic mclk = 1'h0;
  logic arst_n = 1'h0;
  logic hw_reset = 1'h0;
  logic chip_select_n = 1'h1;
  logic read_n = 1'h1;
  logic register_select = 1'h1;
  logic background_trim_n = 1'h1;
  logic [1:0] variant_sel = 2'h0;
  logic fast_grade = 1'h0;
  logic loopback = 1'h0;
  logic strobe_req = 1'h0;
  logic force_req = 1'h0;
  logic sample_strobe_n, conversion_done_n, track_done_n, tracking;
  logic converting, calibrating, acquisition_ok, interleave_active;
  logic trim_update, pd;
  int bad_count = 0;
  int checks = 0;
  int n, k, kt, m, p, d, len;
  typedef struct {logic [1:0] v; logic f; logic t; int b; int a;} row_s;
  row_s rows[5] = '{'{2'h0, 1'h1, 1'h1, 49, 59}, '{2'h1, 1'h0, 1'h1, 49, 96},
    '{2'h2, 1'h0, 1'h1, 57, 96}, '{2'h3, 1'h0, 1'h0, 65, 96},
    '{2'h0, 1'h0, 1'h0, 49, 96}};

  sar_adc_sample_cal_sequencer #(.CAL_FAST12_CYC(40), .CAL_STD_CYC(40),
    .TRIM_FAST12_CONV(3), .TRIM_STD_CONV(3)
  ) sar_adc_sample_cal_sequencer_inst (.mclk, .arst_n, .hw_reset,
    .chip_select_n, .read_n, .register_select, .sample_strobe_n,
    .background_trim_n, .variant_sel, .fast_grade, .conversion_done_n,
    .track_done_n, .tracking, .converting, .calibrating, .acquisition_ok,
    .interleave_active, .trim_update);

  host_strobe_model host_strobe_model_inst (.mclk, .loopback, .strobe_req,
    .force_req, .acquisition_ok, .track_done_n, .sample_strobe_n);

  always #12.5 mclk = ~mclk;

  task automatic cmp_bit(string nm, logic e, logic g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cmp_int(string nm, int e, int g);
    checks++;
    if (g != e) begin
      bad_count++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic cyc(int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask

  task automatic wait_done(output int c);
    c = 0;
    while (conversion_done_n !== 1'h0 && c < 3000) begin
      cyc(1);
      c++;
      if (converting !== 1'h0) m++;
    end
  endtask

  task automatic settle(output int c, output int ct);
    c = 0;
    ct = 0;
    while (acquisition_ok !== 1'h1 && c < 300) begin
      cyc(1);
      c++;
      if (track_done_n === 1'h0 && ct == 0) ct = c;
    end
  endtask

  task automatic hreset();
    @(posedge mclk) hw_reset <= 1'h1;
    cyc(4);
    cmp_bit("cal_hw", 1'h1, calibrating);
    cmp_bit("done_hw", 1'h1, conversion_done_n);
    @(posedge mclk) hw_reset <= 1'h0;
  endtask

  task automatic strobe();
    @(posedge mclk) strobe_req <= 1'h1;
    @(posedge mclk) strobe_req <= 1'h0;
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    bad_count++;
    give_verdict();
  end

  initial begin
    cyc(5);
    cmp_bit("cal_rst", 1'h1, calibrating);
    cmp_bit("done_rst", 1'h1, conversion_done_n);
    cmp_bit("trk_rst", 1'h1, track_done_n);
    @(posedge mclk) arst_n <= 1'h1;
    force_req <= 1'h1;
    strobe_req <= 1'h1;
    @(posedge mclk) strobe_req <= 1'h0;
    #1;
    m = 0;
    wait_done(n);
    force_req <= 1'h0;
    cmp_int("cal_len", 40, n + 1);
    cmp_int("cal_strobe", 0, m);
    foreach (rows[i]) begin
      @(posedge mclk) variant_sel <= rows[i].v;
      fast_grade <= rows[i].f;
      background_trim_n <= rows[i].t;
      chip_select_n <= rows[i].t;
      hreset();
      wait_done(n);
      cmp_bit("ilv", ~rows[i].t, interleave_active);
      settle(k, kt);
      cmp_int("trk_delay", 15, kt);
      cmp_int("acq_time", rows[i].a, k);
      cmp_bit("tracking", 1'h1, tracking);
      @(posedge mclk) chip_select_n <= 1'h0;
      read_n <= 1'h0;
      @(posedge mclk) read_n <= 1'h1;
      chip_select_n <= rows[i].t;
      cyc(4);
      cmp_bit("read_rel", 1'h1, conversion_done_n);
      strobe();
      cyc(1);
      cmp_bit("hold", 1'h1, converting);
      cmp_bit("trk_rise", 1'h1, track_done_n);
      wait_done(n);
      len = rows[i].b + (rows[i].t ? 0 : 20);
      cmp_bit("conv_time", 1'h1, n + 1 >= len && n + 1 <= len + 3);
    end
    for (int j = 0; j < 2; j++) begin
      @(posedge mclk) variant_sel <= 2'h0;
      background_trim_n <= (j == 0);
      chip_select_n <= (j == 0);
      loopback <= 1'h1;
      hreset();
      wait_done(n);
      d = 0;
      m = 0;
      k = 0;
      p = 0;
      pd = 1'h0;
      while (d < 6 && k < 2000) begin
        cyc(1);
        k++;
        if (trim_update === 1'h1) m++;
        if (conversion_done_n === 1'h0 && pd === 1'h1) begin
          if (d > 0) cmp_int("period", 64 + 20 * j, k - p);
          p = k;
          d++;
        end
        pd = conversion_done_n;
      end
      cmp_int("done_count", 6, d);
      cmp_int("trim_pulses", 2 * j, m);
    end
    @(posedge mclk) loopback <= 1'h0;
    variant_sel <= 2'h2;
    background_trim_n <= 1'h1;
    chip_select_n <= 1'h0;
    read_n <= 1'h0;
    hreset();
    n = 0;
    while (calibrating !== 1'h0 && n < 500) begin
      cyc(1);
      n++;
    end
    kt = 0;
    m = 0;
    for (int q = 1; q <= 16; q++) begin
      cyc(1);
      if (conversion_done_n !== 1'h1) m++;
      if (track_done_n === 1'h0 && kt == 0) kt = q;
    end
    cmp_int("alone_done", 0, m);
    cmp_int("alone_trk", 15, kt);
    @(posedge mclk) read_n <= 1'h1;
    chip_select_n <= 1'h1;
    settle(k, kt);
    strobe();
    @(posedge mclk) chip_select_n <= 1'h0;
    register_select <= 1'h0;
    cyc(2);
    cmp_bit("soft_cal", 1'h1, calibrating);
    cmp_bit("soft_conv", 1'h0, converting);
    cmp_bit("soft_done", 1'h1, conversion_done_n);
    @(posedge mclk) chip_select_n <= 1'h1;
    register_select <= 1'h1;
    cyc(2);
    give_verdict();
  end
endmodule
